//--- adc_cmp_pkg.sv
package adc_cmp_pkg;

  localparam logic [19:0] ADDR_MODE_TWO   = 20'hf0010;
  localparam logic [19:0] ADDR_UPPER      = 20'hf0011;
  localparam logic [19:0] ADDR_LOWER      = 20'hf0012;
  localparam logic [19:0] ADDR_RESULT_LO  = 20'hfff1e;
  localparam logic [19:0] ADDR_RESULT_HI  = 20'hfff1f;
  localparam logic [19:0] ADDR_CHAN_SEL   = 20'hfff31;

  localparam logic [7:0]  MODE_TWO_RESET  = 8'h00;
  localparam logic [7:0]  UPPER_RESET     = 8'hff;
  localparam logic [7:0]  LOWER_RESET     = 8'h00;
  localparam logic [7:0]  CHAN_SEL_RESET  = 8'h00;
  localparam logic [15:0] RESULT_RESET    = 16'h0000;

  // Mode register two bit positions
  localparam int BIT_POS_REF1     = 7;
  localparam int BIT_RANGE_CHECK  = 3;
  localparam int BIT_WAKE_CONVERT_MODE       = 2;
  localparam int BIT_RESOLUTION   = 0;
  localparam logic [7:0] MODE_TWO_WMASK = 8'hed;

  // Channel select fields
  localparam int BIT_INT_REF      = 7;
  localparam logic [7:0] CHAN_SEL_WMASK = 8'h9f;

  localparam logic [4:0] CODE_FIRST_PIN  = 5'h08;
  localparam logic [4:0] CODE_LAST_PIN   = 5'h11;
  localparam logic [4:0] CODE_BIAS       = 5'h12;
  localparam logic [4:0] CODE_INT_REF    = 5'h01;
  localparam logic [4:0] CODE_LAST_SCAN  = 5'h0c;

  // Analog source selector values
  localparam logic [3:0] SRC_BIAS        = 4'ha;
  localparam logic [3:0] SRC_INT_REF     = 4'hb;
  localparam logic [3:0] SRC_NONE        = 4'hf;

  localparam int RESULT_SHIFT = 6;

  typedef enum logic [1:0] {
    TRIG_SOFTWARE = 2'b00,
    TRIG_RESERVED = 2'b01,
    TRIG_HW_NOWAIT = 2'b10,
    TRIG_HW_WAIT  = 2'b11
  } trig_mode_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [19:0] addr;
    logic [7:0]  wdata;
  } cpu_req_t;

  typedef struct packed {
    logic       valid;
    logic [9:0] value;
  } conv_done_t;

endpackage : adc_cmp_pkg

//--- range_compare.sv
`timescale 1ns/100ps
module range_compare (
  input  wire logic [9:0] approx_value,
  input  wire logic       range_check_select,
  input  wire logic [7:0] upper_limit,
  input  wire logic [7:0] lower_limit,
  output wire logic       accept
);
  import adc_cmp_pkg::*;

  // At both resolutions the upper eight result bits meet the limits
  wire logic [7:0] cmp_value = approx_value[9:2];
  wire logic       below     = cmp_value < lower_limit;
  wire logic       above     = cmp_value > upper_limit;
  wire logic       inside_window_area = !below && !above;

  assign accept = range_check_select ? (below || above)
                                     : inside_window_area;

endmodule : range_compare

//--- adc_result_compare_channel_ctrl.sv
`timescale 1ns/100ps
module adc_result_compare_channel_ctrl (
  input  wire logic                    clk_sys,
  input  wire logic                    resetn,
  input  wire adc_cmp_pkg::cpu_req_t   cpu_req,
  output      logic [7:0]              cpu_rdata,
  input  wire adc_cmp_pkg::conv_done_t conv_done,
  input  wire logic                    scan_or_select,
  input  wire logic [1:0]              scan_step,
  input  wire logic [1:0]              trigger_mode_field,
  input  wire logic                    conversion_run,
  input  wire logic                    converter_power_on,
  input  wire logic                    stop_mode,
  input  wire logic                    hw_trigger,
  output      logic                    conversion_end_irq,
  output      logic [3:0]              analog_source,
  output      logic                    channel_prohibited,
  output      logic                    resolution_eight,
  output      logic                    trig_software,
  output      logic                    trig_hw_nowait,
  output      logic                    trig_hw_wait,
  output      logic                    wake_convert_mode_wake,
  output      logic                    channel_write,
  output      logic                    positive_ref_select
);
  import adc_cmp_pkg::*;

  logic       rst_meta_r;
  logic       rst_sync_r;
  logic [7:0] mode_two_r;
  logic [7:0] upper_r;
  logic [7:0] lower_r;
  logic [7:0] chan_sel_r;
  logic [9:0] result_r;
  logic       irq_r;
  logic       wake_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // Reset is released through two stages so the whole block leaves reset together
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  wire logic rst_n = rst_sync_r;

  // Address decode
  wire logic hit_mode_two  = cpu_req.addr == ADDR_MODE_TWO;
  wire logic hit_upper     = cpu_req.addr == ADDR_UPPER;
  wire logic hit_lower     = cpu_req.addr == ADDR_LOWER;
  wire logic hit_result_lo = cpu_req.addr == ADDR_RESULT_LO;
  wire logic hit_result_hi = cpu_req.addr == ADDR_RESULT_HI;
  wire logic hit_chan_sel  = cpu_req.addr == ADDR_CHAN_SEL;

  wire logic wr_mode_two = cpu_req.wr && hit_mode_two;
  wire logic wr_upper    = cpu_req.wr && hit_upper;
  wire logic wr_lower    = cpu_req.wr && hit_lower;
  wire logic wr_chan_sel = cpu_req.wr && hit_chan_sel;

  // Mode register fields
  wire logic range_check_select = mode_two_r[BIT_RANGE_CHECK];
  wire logic wake_convert_mode_enable      = mode_two_r[BIT_WAKE_CONVERT_MODE];
  wire logic resolution_select  = mode_two_r[BIT_RESOLUTION];

  // Channel select fields
  wire logic       internal_ref_input_select = chan_sel_r[BIT_INT_REF];
  wire logic [4:0] channel_code              = chan_sel_r[4:0];

  // Range comparison decides both the irq and the result update
  logic accept;

  range_compare u_range_compare (
    .approx_value       (conv_done.value),
    .range_check_select (range_check_select),
    .upper_limit        (upper_r),
    .lower_limit        (lower_r),
    .accept             (accept)
  );

  // Eight-bit conversions drop the two low bits before storage
  wire logic [9:0] conv_value = resolution_select ?
                                {conv_done.value[9:2], 2'b00} : conv_done.value;
  wire logic       store      = conv_done.valid && accept;

  // Registers. Writes to the mode and limit registers are taken at any time;
  // the caller must hold the converter idle, which this block does not police.
  wire logic [7:0] mode_two_nxt = wr_mode_two ? (cpu_req.wdata & MODE_TWO_WMASK)
                                              : mode_two_r;
  wire logic [7:0] upper_nxt    = wr_upper ? cpu_req.wdata : upper_r;
  wire logic [7:0] lower_nxt    = wr_lower ? cpu_req.wdata : lower_r;
  // Bits 6:5 are forced to zero whatever software writes
  wire logic [7:0] chan_sel_nxt = wr_chan_sel ? (cpu_req.wdata & CHAN_SEL_WMASK)
                                              : chan_sel_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_two_r <= MODE_TWO_RESET;
    end else begin
      mode_two_r <= mode_two_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      upper_r <= UPPER_RESET;
    end else begin
      upper_r <= upper_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lower_r <= LOWER_RESET;
    end else begin
      lower_r <= lower_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chan_sel_r <= CHAN_SEL_RESET;
    end else begin
      chan_sel_r <= chan_sel_nxt;
    end
  end

  // Result and interrupt; a suppressed conversion leaves the old result intact
  wire logic [9:0] result_nxt = store ? conv_value : result_r;
  wire logic       irq_nxt    = store;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      result_r <= RESULT_RESET[9:0];
    end else begin
      result_r <= result_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // Wake_convert_mode: hardware trigger in stop mode wakes the converter only
  wire logic wake_nxt = wake_convert_mode_enable && stop_mode && hw_trigger;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= wake_nxt;
    end
  end

  // Read mux; result words are left-justified with low six bits zero
  wire logic [15:0] result_word = {result_r, 6'b00_0000};

  always_comb begin
    rdata_nxt = 8'h00;
    if (hit_mode_two) begin
      rdata_nxt = mode_two_r;
    end else if (hit_upper) begin
      rdata_nxt = upper_r;
    end else if (hit_lower) begin
      rdata_nxt = lower_r;
    end else if (hit_result_lo) begin
      rdata_nxt = result_word[7:0];
    end else if (hit_result_hi) begin
      rdata_nxt = result_word[15:8];
    end else if (hit_chan_sel) begin
      rdata_nxt = chan_sel_r;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else if (cpu_req.rd) begin
      rdata_r <= rdata_nxt;
    end
  end

  // Each scan step's source is formed up front; the current step then picks one
  wire logic [3:0] scan_src [4];

  for (genvar s = 0; s < 4; s++) begin : g_scan_step
    wire logic [4:0] step_code = channel_code + 5'(s);
    assign scan_src[s] = 4'(step_code - CODE_FIRST_PIN);
  end

  // Channel decode
  wire logic       pin_code  = channel_code >= CODE_FIRST_PIN &&
                               channel_code <= CODE_LAST_PIN;
  wire logic       scan_ok   = !internal_ref_input_select &&
                               channel_code >= CODE_FIRST_PIN &&
                               channel_code <= CODE_LAST_SCAN;
  wire logic       ref_ok    = internal_ref_input_select &&
                               channel_code == CODE_INT_REF;
  wire logic       bias_ok   = !internal_ref_input_select &&
                               channel_code == CODE_BIAS;
  wire logic       sel_pin   = !internal_ref_input_select && pin_code;
  wire logic [4:0] pin_index = channel_code - CODE_FIRST_PIN;

  always_comb begin
    analog_source      = SRC_NONE;
    channel_prohibited = 1'b0;
    if (scan_or_select) begin
      if (scan_ok) begin
        analog_source = scan_src[scan_step];
      end else begin
        channel_prohibited = 1'b1;
      end
    end else if (sel_pin) begin
      analog_source = pin_index[3:0];
    end else if (bias_ok) begin
      analog_source = SRC_BIAS;
    end else if (ref_ok) begin
      analog_source = SRC_INT_REF;
    end else begin
      channel_prohibited = 1'b1;
    end
  end

  // Trigger mode decode; code 01 is treated as software trigger
  wire logic t_hw_nowait = trigger_mode_field == TRIG_HW_NOWAIT;
  wire logic t_hw_wait   = trigger_mode_field == TRIG_HW_WAIT;

  assign cpu_rdata           = rdata_r;
  assign conversion_end_irq  = irq_r;
  assign resolution_eight    = resolution_select;
  assign trig_software       = !t_hw_nowait && !t_hw_wait;
  assign trig_hw_nowait      = t_hw_nowait;
  assign trig_hw_wait        = t_hw_wait;
  assign wake_convert_mode_wake         = wake_r;
  assign channel_write       = wr_chan_sel;
  assign positive_ref_select = mode_two_r[BIT_POS_REF1];

endmodule : adc_result_compare_channel_ctrl

//--- adc_ctrl_chk.sv
`timescale 1ns/100ps
module adc_ctrl_chk (
  input wire logic                    clk_sys,
  input wire logic                    resetn,
  input wire adc_cmp_pkg::cpu_req_t   cpu_req,
  input wire logic [7:0]              cpu_rdata,
  input wire adc_cmp_pkg::conv_done_t conv_done,
  input wire logic [1:0]              trigger_mode_field,
  input wire logic                    stop_mode,
  input wire logic                    hw_trigger,
  input wire logic                    conversion_end_irq,
  input wire logic                    wake_convert_mode_wake,
  input wire logic                    resolution_eight,
  input wire logic                    trig_software,
  input wire logic                    trig_hw_nowait,
  input wire logic                    trig_hw_wait,
  input wire logic                    channel_write
);
  import adc_cmp_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_mode_wr; cpu_req.wr && cpu_req.addr == ADDR_MODE_TWO; endsequence
  sequence s_lo_rd; cpu_req.rd && cpu_req.addr == ADDR_RESULT_LO; endsequence
  property p_irq; conversion_end_irq |-> $past(conv_done.valid); endproperty
  property p_res; s_mode_wr |=> resolution_eight == $past(cpu_req.wdata[0]); endproperty
  property p_lo; s_lo_rd |=> cpu_rdata[5:0] == 6'h00; endproperty
  property p_wake; wake_convert_mode_wake |-> $past(hw_trigger) && $past(stop_mode); endproperty
  property p_sw; trig_software == !trigger_mode_field[1]; endproperty
  property p_hw; {trig_hw_nowait, trig_hw_wait} == {trigger_mode_field == 2'h2,
    trigger_mode_field == 2'h3}; endproperty
  property p_chw; cpu_req.wr && cpu_req.addr == ADDR_CHAN_SEL |-> channel_write; endproperty
  property p_hold; !$past(cpu_req.rd) |-> $stable(cpu_rdata); endproperty
  a_irq: assert property (p_irq) else $error("irq without conversion end");
  a_res: assert property (p_res) else $error("resolution level wrong");
  a_lo: assert property (p_lo) else $error("low result bits not zero");
  a_wake: assert property (p_wake) else $error("wake without trigger in stop");
  a_sw: assert property (p_sw) else $error("software trigger decode");
  a_hw: assert property (p_hw) else $error("hardware trigger decode");
  a_chw: assert property (p_chw) else $error("channel write not flagged");
  a_hold: assert property (p_hold) else $error("read data moved without read");
endmodule : adc_ctrl_chk
bind adc_result_compare_channel_ctrl adc_ctrl_chk u_chk (.*);

//--- analog_front.sv
`timescale 1ns/100ps
module analog_front (
  input  wire logic                    clk_sys,
  input  wire logic                    start,
  input  wire logic                    slow,
  input  wire logic [9:0]              vin,
  output      adc_cmp_pkg::conv_done_t conv_done
);
  import adc_cmp_pkg::*;
  int         cnt  = 0;
  logic [9:0] last = 10'h000;
  initial conv_done = '0;
  always @(posedge clk_sys) begin
    #5;
    if (cnt == 1) last = vin;
    // Idle value bus shows the inverse so a stale sample never passes
    conv_done = (cnt == 1) ? {1'b1, vin} : {1'b0, ~last};
    cnt = start ? (slow ? 9 : 3) : (cnt > 0 ? cnt - 1 : 0);
  end
endmodule : analog_front

//--- adc_result_compare_channel_ctrl_tb_top.sv
`timescale 1ns/100ps
module adc_result_compare_channel_ctrl_tb_top;
  import adc_cmp_pkg::*;
  logic clk_sys = 1'b0, resetn = 1'b0, start = 1'b0, slow = 1'b0, stop_mode = 1'b0;
  logic hw_trigger = 1'b0, scan_or_select = 1'b0, conversion_run = 1'b0;
  logic converter_power_on = 1'b0;
  logic [1:0] scan_step = 2'h0, trigger_mode_field = 2'h0;
  logic [9:0] vin = 10'h000;
  cpu_req_t   cpu_req = '0;
  conv_done_t conv_done;
  logic [7:0] cpu_rdata, exp_hi = 8'h00, exp_lo = 8'h00;
  logic [3:0] analog_source;
  logic conversion_end_irq, channel_prohibited, resolution_eight, trig_software;
  logic trig_hw_nowait, trig_hw_wait, wake_convert_mode_wake, channel_write, positive_ref_select;
  int   n_mismatch = 0, n_checks = 0;
  initial forever #50 clk_sys = ~clk_sys;
  adc_result_compare_channel_ctrl dut (.*);
  analog_front far_side (.*);
  task automatic tick(); @(posedge clk_sys); #10; endtask : tick
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic bus(logic w, logic [19:0] a, logic [7:0] d);
    cpu_req = {w, !w, a, d};
    tick();
    cpu_req = '0;
    tick();
  endtask : bus
  task automatic rd(logic [19:0] a, logic [7:0] e, string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, cpu_rdata, e);
  endtask : rd
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  function automatic logic accept(logic [9:0] v, logic ck, logic [7:0] lo, logic [7:0] up);
    return ck ? (v[9:2] < lo || v[9:2] > up) : (v[9:2] >= lo && v[9:2] <= up);
  endfunction : accept
  // Bit 4 marks a prohibited code
  function automatic logic [4:0] route(logic sc, logic ir, logic [4:0] c, logic [1:0] st);
    if (!sc && ir) return (c == 5'h01) ? 5'h0b : 5'h1f;
    if (!sc && c >= 5'h08 && c <= 5'h12) return c - 5'h08;
    if (sc && !ir && c >= 5'h08 && c <= 5'h0c) return c - 5'h08 + st;
    return 5'h1f;
  endfunction : route
  initial begin
    int k;
    logic [7:0] lo, up;
    logic ck, r8, ok;
    logic [4:0] e;
    k = $urandom(32'h6348fbcf);
    repeat (12) @(posedge clk_sys);
    #10 resetn = 1'b1;
    repeat (4) tick();
    rd(ADDR_MODE_TWO, 8'h00, "mode");
    rd(ADDR_UPPER, 8'hff, "upper");
    rd(ADDR_LOWER, 8'h00, "lower");
    rd(ADDR_RESULT_LO, 8'h00, "res_lo");
    rd(ADDR_RESULT_HI, 8'h00, "res_hi");
    rd(ADDR_CHAN_SEL, 8'h00, "chan");
    rd(20'hf0013, 8'h00, "hole");
    bus(1'b1, ADDR_MODE_TWO, 8'hff);
    rd(ADDR_MODE_TWO, 8'hed, "mode_mask");
    chk("res8", resolution_eight, 1'b1);
    chk("pref", positive_ref_select, 1'b1);
    bus(1'b1, ADDR_RESULT_HI, 8'h5a);
    rd(ADDR_RESULT_HI, 8'h00, "hi_ro");
    bus(1'b1, ADDR_MODE_TWO, 8'h00);
    chk("pref_off", positive_ref_select, 1'b0);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      trigger_mode_field = i[1:0];
      tick();
      chk("trig", {trig_software, trig_hw_nowait, trig_hw_wait}, {i < 2, i == 2, i == 3});
    end
    for (int i = 0; i < 128; i++) begin
      scan_or_select = i[6];
      scan_step = 2'($urandom);
      bus(1'b1, ADDR_CHAN_SEL, {i[5], 2'b00, i[4:0]});
      e = route(i[6], i[5], i[4:0], scan_step);
      chk("prohib", channel_prohibited, e[4]);
      if (!e[4]) chk("source", analog_source, e[3:0]);
    end
    scan_or_select = 1'b0;
    $display("test channels done");
    for (int i = 0; i < 60; i++) begin
      lo = 8'($urandom_range(200));
      up = lo + 8'd1 + 8'($urandom_range(254 - lo));
      ck = 1'($urandom);
      r8 = 1'($urandom);
      slow = 1'($urandom);
      vin = (i % 4 == 0) ? {lo, 2'b11} : (i % 4 == 1) ? {up, 2'b01} : 10'($urandom);
      bus(1'b1, ADDR_UPPER, up);
      bus(1'b1, ADDR_LOWER, lo);
      bus(1'b1, ADDR_MODE_TWO, {4'h0, ck, 2'b00, r8});
      start = 1'b1;
      tick();
      start = 1'b0;
      k = 0;
      while (!conv_done.valid && k < 20) begin
        tick();
        k++;
      end
      if (k == 20) begin
        n_mismatch++;
        report_and_stop();
      end
      tick();
      ok = accept(vin, ck, lo, up);
      chk("irq", conversion_end_irq, ok);
      if (ok) begin
        exp_hi = vin[9:2];
        exp_lo = r8 ? 8'h00 : {vin[1:0], 6'h00};
      end
      rd(ADDR_RESULT_HI, exp_hi, "res_hi");
      rd(ADDR_RESULT_LO, exp_lo, "res_lo");
    end
    $display("test compare done");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, ADDR_MODE_TWO, {5'h00, i[0], 2'b00});
      stop_mode = i[1];
      hw_trigger = 1'b1;
      tick();
      hw_trigger = 1'b0;
      chk("wake", wake_convert_mode_wake, i[0] & i[1]);
    end
    bus(1'b1, ADDR_MODE_TWO, 8'h00);
    $display("test wake_convert_mode done");
    report_and_stop();
  end
endmodule : adc_result_compare_channel_ctrl_tb_top
